// [rtl/rxsleep_pkg.sv]
package rxsleep_pkg;
  // ****************************************
  // Register offsets (APB byte addresses)
  // ****************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_OPEN      = 8'h08;
  localparam logic [7:0]  OFS_NOTE_ACK  = 8'h0c;
  localparam logic [7:0]  OFS_ACCESS    = 8'h10;
  localparam logic [7:0]  OFS_WINDOW    = 8'h14;
  localparam logic [7:0]  OFS_HOST_RESP = 8'h18;
  localparam logic [7:0]  OFS_BUSY      = 8'h1c;
  // ****************************************
  // Command and return codes
  // ****************************************
  localparam logic [7:0]  CMD_RX_FILTER = 8'h1f;
  localparam logic [7:0]  CMD_SLEEP     = 8'h05;
  localparam logic [7:0]  RC_OK         = 8'h00;
  localparam logic [7:0]  RC_BAD_CMD    = 8'h01;
  localparam logic [7:0]  RC_CLOSED     = 8'h04;
  localparam logic [7:0]  RC_BAD_OPT    = 8'h06;
  localparam logic [7:0]  RC_NO_BUF     = 8'h20;
  localparam logic [15:0] RXOPT_NORMAL  = 16'h0000;
  localparam logic [15:0] RXOPT_MAC     = 16'h0002;
  localparam logic [15:0] RXOPT_PROMISC = 16'h0004;
  localparam logic [15:0] RXOPT_LLC_ALL = 16'h0006;
  localparam logic [15:0] WAKE_MAGIC    = 16'h0001;
  localparam logic [15:0] WAKE_PATTERN  = 16'h0002;
  localparam logic [15:0] WAKE_BOTH     = 16'h0003;
  localparam int          OPEN_FWD_BIT  = 15;
  localparam int          OPEN_FWD_HI   = 4;
  localparam int          OPEN_FWD_LO   = 3;
  // ****************************************
  // Request block and local access
  // ****************************************
  localparam logic [7:0]  NOTE_RX       = 8'h81;
  localparam logic [7:0]  NOTE_RING     = 8'h84;
  localparam logic [7:0]  NCB_I_FRAME   = 8'h04;
  localparam logic [19:0] NOTE_BASE     = 20'hd08a0;
  localparam logic [19:0] NOTE_BYTES    = 20'h00010;
  localparam int          NOTE_WORDS    = 8;
  localparam int          NOTE_IDX_W    = 3;
  localparam logic [3:0]  OP_PRIV_READ  = 4'h1;
  localparam logic [15:0] CHAIN_END     = 16'h0000;
  localparam logic [15:0] CHAIN_STEP    = 16'h0002;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          ST_DONE       = 8;
  localparam int          ST_BUSY       = 9;
  localparam int          ST_OPEN       = 10;
  localparam int          ST_ASLEEP     = 11;
  localparam int          ST_PENDING    = 12;
  localparam int          ST_LBUSY      = 13;
  localparam int          OPEN_EN_BIT   = 16;
  localparam int          ACC_OP_LSB    = 20;
  localparam int          ACC_WORD_BIT  = 24;
  localparam logic [15:0] RST_RXOPT     = 16'h0000;

  typedef enum logic [1:0] {CMD_IDLE, CMD_EXEC, CMD_SLEEP_ENTER} cmd_state_e;
  typedef enum logic [1:0] {NOTE_IDLE, NOTE_FILL, NOTE_POST} note_state_e;
endpackage : rxsleep_pkg

// [rtl/rx_filter_decide.sv]
`timescale 1ns/100ps
module rx_filter_decide #(
  parameter int OPT_W = 16
) (
  input  wire logic [OPT_W-1:0] rx_opt,
  input  wire logic [15:0]      open_opt,
  input  wire logic             is_mac,
  input  wire logic             addr_match,
  output logic                  accept,
  output logic                  forward
);
  import rxsleep_pkg::*;

  generate
    if (OPT_W < 16) begin : g_bad_width
      $error("rx option width below 16");
    end
  endgenerate

  logic mac_fwd;
  logic promisc;

  assign mac_fwd = open_opt[OPEN_FWD_BIT] | open_opt[OPEN_FWD_HI] | open_opt[OPEN_FWD_LO];
  assign promisc = (rx_opt[15:0] == RXOPT_PROMISC);

  always_comb begin
    unique case (rx_opt[15:0])
      RXOPT_MAC:     accept = is_mac & addr_match;
      RXOPT_PROMISC: accept = 1'b1;
      RXOPT_LLC_ALL: accept = is_mac ? addr_match : 1'b1;
      default:       accept = addr_match;
    endcase
    // MAC frames reach the host only with open-time forwarding or promiscuous
    forward = accept & (is_mac ? (mac_fwd | promisc) : 1'b1);
  end
endmodule : rx_filter_decide

// [rtl/request_block_store.sv]
`timescale 1ns/100ps
module request_block_store #(
  parameter int WORDS = 8,
  parameter int WIDTH = 16,
  parameter int IDX_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [IDX_W-1:0] waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [IDX_W-1:0] raddr,
  output logic      [WIDTH-1:0] rdata
);
  generate
    if (WORDS > (1 << IDX_W) || WORDS < 2) begin : g_bad_depth
      $error("request block depth does not fit index");
    end
  endgenerate

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
  } store_s;

  store_s st;
  store_s next_st;

  always_comb begin
    next_st = st;
    if (we) begin
      next_st.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.mem[raddr];
endmodule : request_block_store

// [rtl/rx_filter_sleep_arb_notify.sv]
`timescale 1ns/100ps
module rx_filter_sleep_arb_notify (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [rxsleep_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            frame_valid,
  input  wire logic                            frame_is_mac,
  input  wire logic                            frame_addr_match,
  input  wire logic                            frame_magic_hit,
  input  wire logic                            frame_pattern_hit,
  input  wire logic [7:0]                      frame_ncb,
  input  wire logic [15:0]                     frame_station,
  input  wire logic [15:0]                     frame_buf,
  input  wire logic [15:0]                     frame_len,
  input  wire logic [15:0]                     frame_next_buf,
  input  wire logic                            frame_last,
  input  wire logic                            ring_status_valid,
  input  wire logic [15:0]                     ring_status,
  output logic                                 frame_accept,
  output logic                                 frame_forward,
  output logic                                 frame_to_local,
  output logic                                 llc_tx_enable,
  output logic                                 ring_inserted,
  output logic                                 host_irq,
  output logic                                 wake_irq,
  output logic                                 local_busy,
  output logic      [15:0]                     chain_link
);
  import rxsleep_pkg::*;

  typedef struct packed {
    cmd_state_e             cst;
    logic [7:0]             cmd_code;
    logic [15:0]            cmd_opt;
    logic [7:0]             ret;
    logic                   done;
    logic                   is_open;
    logic [15:0]            open_opt;
    logic [15:0]            rx_opt;
    logic [15:0]            wake_sel;
    logic                   asleep;
    logic                   wake_irq;
    note_state_e            nst;
    logic [NOTE_IDX_W-1:0]  widx;
    logic [7:0]             ncode;
    logic [15:0]            nbuf;
    logic [15:0]            nlen;
    logic [15:0]            nstat;
    logic [7:0]             nncb;
    logic                   pending;
    logic                   rs_wait;
    logic [15:0]            rs_val;
    logic [19:0]            ptr;
    logic [3:0]             op;
    logic                   wsize;
    logic [7:0]             last_ncb;
    logic                   local_busy;
    logic [15:0]            chain;
    logic [31:0]            prdata;
    logic                   pslverr;
  } state_s;

  state_s                 st;
  state_s                 next_st;
  logic                   wr_acc;
  logic                   rd_setup;
  logic                   hit;
  logic [31:0]            rd_word;
  logic                   flt_accept;
  logic                   flt_forward;
  logic                   mem_we;
  logic [15:0]            mem_wdata;
  logic [15:0]            mem_rdata;
  logic [19:0]            win_off;
  logic                   win_ok;
  logic                   note_free;
  logic                   wake_match;

  // ****************************************
  // Sub-blocks
  // ****************************************
  rx_filter_decide #(.OPT_W(16)) u_filter (
    .rx_opt     (st.rx_opt),
    .open_opt   (st.open_opt),
    .is_mac     (frame_is_mac),
    .addr_match (frame_addr_match),
    .accept     (flt_accept),
    .forward    (flt_forward)
  );

  request_block_store #(.WORDS(NOTE_WORDS), .WIDTH(16), .IDX_W(NOTE_IDX_W)) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .waddr (st.widx),
    .wdata (mem_wdata),
    .raddr (win_off[NOTE_IDX_W:1]),
    .rdata (mem_rdata)
  );

  // ****************************************
  // APB decode and read mux
  // ****************************************
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign win_off  = st.ptr - NOTE_BASE;
  assign win_ok   = (st.op == OP_PRIV_READ) && (st.ptr >= NOTE_BASE)
                    && (win_off < NOTE_BYTES);

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFS_CMD:       rd_word = {8'h00, st.cmd_opt, st.cmd_code};
      OFS_STATUS:    rd_word = {18'h00000, st.local_busy, st.pending, st.asleep,
                                st.is_open, (st.cst != CMD_IDLE), st.done, st.ret};
      OFS_OPEN:      rd_word = {15'h0000, st.is_open, st.open_opt};
      OFS_NOTE_ACK:  rd_word = 32'h0000_0000;
      OFS_ACCESS:    rd_word = {7'h00, st.wsize, st.op, st.ptr};
      // Window reads only look; the pointer stays put
      OFS_WINDOW: begin
        if (win_ok) begin
          if (st.wsize) begin
            rd_word = {16'h0000, mem_rdata};
          end else begin
            rd_word = {24'h000000, win_off[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
          end
        end
      end
      OFS_HOST_RESP: rd_word = {24'h000000, st.last_ncb};
      OFS_BUSY:      rd_word = {31'h00000000, st.local_busy};
      default:       hit = 1'b0;
    endcase
  end

  // ****************************************
  // Notice word layout
  // ****************************************
  always_comb begin
    unique case (st.widx)
      3'd0:    mem_wdata = {8'h00, st.ncode};
      3'd3:    mem_wdata = (st.ncode == NOTE_RING) ? st.nstat : st.nbuf;
      3'd5:    mem_wdata = st.nlen;
      3'd6:    mem_wdata = {8'h00, st.nncb};
      default: mem_wdata = 16'h0000;
    endcase
  end

  assign mem_we     = (st.nst == NOTE_FILL);
  assign note_free  = (st.nst == NOTE_IDLE) && !st.pending && (st.cst == CMD_IDLE);
  assign wake_match = ((st.wake_sel != WAKE_PATTERN) && frame_magic_hit)
                    | ((st.wake_sel != WAKE_MAGIC) && frame_pattern_hit);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st          = st;
    next_st.wake_irq = 1'b0;
    if (rd_setup) begin
      next_st.prdata  = rd_word;
      next_st.pslverr = !hit;
    end
    if (psel & ~penable & pwrite) begin
      next_st.pslverr = !hit;
    end
    // Register writes; hardware sets later in this block win over clears
    if (wr_acc) begin
      unique case (paddr)
        OFS_CMD: begin
          // Asleep: dropped with no response at all
          if (!st.asleep && st.cst == CMD_IDLE) begin
            next_st.cmd_code = pwdata[7:0];
            next_st.cmd_opt  = pwdata[23:8];
            next_st.done     = 1'b0;
            next_st.cst      = CMD_EXEC;
          end
        end
        OFS_OPEN: begin
          next_st.open_opt = pwdata[15:0];
          next_st.is_open  = pwdata[OPEN_EN_BIT];
        end
        OFS_NOTE_ACK:  next_st.pending = 1'b0;
        OFS_ACCESS: begin
          next_st.ptr   = pwdata[19:0];
          next_st.op    = pwdata[ACC_WORD_BIT-1:ACC_OP_LSB];
          next_st.wsize = pwdata[ACC_WORD_BIT];
        end
        OFS_HOST_RESP: begin
          if (pwdata[7:0] == RC_NO_BUF && st.last_ncb == NCB_I_FRAME) begin
            next_st.local_busy = 1'b1;
          end
        end
        OFS_BUSY: begin
          if (pwdata[0] && !(st.local_busy && !next_st.local_busy)) begin
            next_st.local_busy = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Command interpreter
    unique case (st.cst)
      CMD_IDLE: ;
      CMD_EXEC: begin
        next_st.done = 1'b1;
        next_st.cst  = CMD_IDLE;
        unique case (st.cmd_code)
          CMD_RX_FILTER: begin
            if (!st.is_open) begin
              next_st.ret = RC_CLOSED;
            end else if (st.cmd_opt == RXOPT_NORMAL || st.cmd_opt == RXOPT_MAC
                      || st.cmd_opt == RXOPT_PROMISC || st.cmd_opt == RXOPT_LLC_ALL) begin
              next_st.rx_opt = st.cmd_opt;
              next_st.ret    = RC_OK;
            end else begin
              next_st.ret = RC_BAD_OPT;
            end
          end
          CMD_SLEEP: begin
            if (!st.is_open) begin
              next_st.ret = RC_CLOSED;
            end else if (st.cmd_opt == WAKE_MAGIC || st.cmd_opt == WAKE_PATTERN
                      || st.cmd_opt == WAKE_BOTH) begin
              next_st.wake_sel = st.cmd_opt;
              next_st.ret      = RC_OK;
              next_st.cst      = CMD_SLEEP_ENTER;
            end else begin
              next_st.ret = RC_BAD_OPT;
            end
          end
          default: next_st.ret = RC_BAD_CMD;
        endcase
      end
      // Response is already posted when sleep begins
      CMD_SLEEP_ENTER: begin
        next_st.asleep = 1'b1;
        next_st.cst    = CMD_IDLE;
      end
    endcase

    // Receive path
    if (frame_valid && (frame_to_local || flt_accept)) begin
      next_st.chain = frame_last ? CHAIN_END : frame_next_buf + CHAIN_STEP;
    end
    if (st.asleep) begin
      if (frame_valid && !frame_is_mac && wake_match && !st.wake_irq) begin
        next_st.wake_irq = 1'b1;
      end
      if (st.wake_irq) begin
        next_st.asleep = 1'b0;
      end
    end else if (st.is_open) begin
      // A receive notice arriving while the block is busy is lost, not queued
      if (frame_valid && flt_forward && note_free) begin
        next_st.ncode    = NOTE_RX;
        next_st.nbuf     = frame_buf;
        next_st.nlen     = frame_len;
        next_st.nncb     = frame_ncb;
        next_st.last_ncb = frame_ncb;
        next_st.nst      = NOTE_FILL;
        next_st.widx     = '0;
      end else if (st.rs_wait && note_free) begin
        next_st.ncode   = NOTE_RING;
        next_st.nstat   = st.rs_val;
        next_st.nbuf    = 16'h0000;
        next_st.nlen    = 16'h0000;
        next_st.nncb    = 8'h00;
        next_st.rs_wait = 1'b0;
        next_st.nst     = NOTE_FILL;
        next_st.widx    = '0;
      end
      // Latest status kept; reported once the block frees
      if (ring_status_valid) begin
        next_st.rs_wait = 1'b1;
        next_st.rs_val  = ring_status;
      end
    end

    // Notice engine: all words written before the flag
    unique case (st.nst)
      NOTE_IDLE: ;
      NOTE_FILL: begin
        if (st.widx == NOTE_IDX_W'(NOTE_WORDS - 1)) begin
          next_st.nst = NOTE_POST;
        end else begin
          next_st.widx = st.widx + 3'd1;
        end
      end
      NOTE_POST: begin
        next_st.pending = 1'b1;
        next_st.nst     = NOTE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st        <= '0;
      st.cst    <= CMD_IDLE;
      st.nst    <= NOTE_IDLE;
      st.rx_opt <= RST_RXOPT;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata         = st.prdata;
  assign pslverr        = st.pslverr;
  assign frame_accept   = frame_valid & ~st.asleep & st.is_open & flt_accept;
  assign frame_forward  = frame_accept & flt_forward;
  assign frame_to_local = frame_valid & st.asleep & ~frame_is_mac;
  assign llc_tx_enable  = st.is_open & ~st.asleep;
  assign ring_inserted  = st.is_open;
  assign host_irq       = st.pending;
  assign wake_irq       = st.wake_irq;
  assign local_busy     = st.local_busy;
  assign chain_link     = st.chain;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SLEEP_AFTER_RESP:
    assert property ($rose(st.asleep) |-> $past(st.done) && st.ret == RC_OK)
      else $error("sleep entered before response");
  AST_ASLEEP_IGNORE:
    assert property (st.asleep && wr_acc && paddr == OFS_CMD && st.cst == CMD_IDLE
                     |=> ##1 $stable(st.ret) && st.cst == CMD_IDLE)
      else $error("command answered while asleep");
  AST_NO_TX_ASLEEP:
    assert property (st.asleep |-> !llc_tx_enable && !frame_forward)
      else $error("transmit or forward while asleep");
  AST_RING_QUIET:
    assert property (st.asleep && !st.rs_wait |=> !st.rs_wait)
      else $error("ring change taken while asleep");
  AST_WAKE_EXIT:
    assert property ($rose(wake_irq) |=> !st.asleep ##1 !wake_irq)
      else $error("sleep not left after wake");
  AST_PENDING_LAST:
    assert property ($rose(host_irq) |-> $past(st.nst == NOTE_POST)
                     && $past(st.widx == 3'd7, 2))
      else $error("pending set before block filled");
  AST_PTR_HOLD:
    assert property (!(wr_acc && paddr == OFS_ACCESS) |=> $stable(st.ptr))
      else $error("access pointer moved");
  AST_CHAIN_END:
    assert property (frame_valid && frame_to_local && frame_last |=> chain_link == CHAIN_END)
      else $error("last buffer link not zero");
  AST_BAD_WAKE:
    assert property (st.cst == CMD_EXEC && st.cmd_code == CMD_SLEEP && st.is_open
                     && st.cmd_opt == 16'h0000 |=> st.ret == RC_BAD_OPT && !st.asleep)
      else $error("bad wake select accepted");
  AST_CLOSED:
    assert property (st.cst == CMD_EXEC && !st.is_open |=> st.done [*2])
      else $error("closed command not completed");

  COV_SLEEP:   cover property ($rose(st.asleep));
  COV_WAKE:    cover property ($rose(wake_irq) ##1 !st.asleep);
  COV_RING:    cover property ($rose(host_irq) && st.ncode == NOTE_RING);
  COV_PROMISC: cover property (st.rx_opt == RXOPT_PROMISC && frame_forward && frame_is_mac);
endmodule : rx_filter_sleep_arb_notify

// [testbench/host_drv.sv]
`timescale 1ns/100ps
// ****************************************
// Host driver model: APB master side
// ****************************************
module host_drv (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  import rxsleep_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look valid
    @(posedge clk);
  endtask : xfer
  // Pointer is rewritten before every window read
  task automatic note_rd(input logic [19:0] a, output logic [31:0] q);
    xfer(1'b1, OFS_ACCESS, {7'h00, 1'b1, OP_PRIV_READ, a}, q);
    xfer(1'b0, OFS_WINDOW, 32'h0, q);
  endtask : note_rd
endmodule : host_drv

// [testbench/rx_filter_sleep_arb_notify_tb.sv]
`timescale 1ns/100ps
module rx_filter_sleep_arb_notify_tb;
  import rxsleep_pkg::*;
  logic        clk, rst_n, fv, mac, am, mh, ph, fl, rv, psel, penable, pwrite, pready, pslverr;
  logic        acc, fwd, loc, txe, ins, hirq, wirq, lbusy;
  logic [7:0]  paddr, ncb;
  logic [15:0] fbuf, flen, fnb, rs, chain;
  logic [31:0] pwdata, prdata, q;
  int          errors, n_checks, i;
  // Rows: option, mac, addr match, accept, forward
  logic [19:0] rows[10] = '{20'h00007, 20'h00000, 20'h0000e, 20'h00024, 20'h0002e,
                           20'h00043, 20'h0004b, 20'h00063, 20'h00068, 20'h0006e};
  host_drv host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));
  rx_filter_sleep_arb_notify dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_valid(fv), .frame_is_mac(mac), .frame_addr_match(am),
    .frame_magic_hit(mh), .frame_pattern_hit(ph), .frame_ncb(ncb), .frame_station(16'h0000),
    .frame_buf(fbuf), .frame_len(flen), .frame_next_buf(fnb), .frame_last(fl),
    .ring_status_valid(rv), .ring_status(rs), .frame_accept(acc), .frame_forward(fwd),
    .frame_to_local(loc), .llc_tx_enable(txe), .ring_inserted(ins), .host_irq(hirq),
    .wake_irq(wirq), .local_busy(lbusy), .chain_link(chain));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cmd(input logic [15:0] opt, input logic [7:0] code, input logic [7:0] exp);
    int n;
    host_u.xfer(1'b1, OFS_CMD, {8'h00, opt, code}, q);
    n = 0;
    q = 32'h0;
    while (q[ST_DONE] !== 1'b1 && n < 20) begin
      host_u.xfer(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end
    chk({24'h0, q[7:0]}, {24'h0, exp});
  endtask : cmd
  task automatic frame(input logic m, a, h, ea, ef, el);
    fv <= 1'b1;
    mac <= m;
    am <= a;
    mh <= h;
    @(negedge clk);
    chk({29'h0, acc, fwd, loc}, {29'h0, ea, ef, el});
    @(posedge clk);
    fv <= 1'b0;
  endtask : frame
  task automatic wait_irq;
    int n;
    n = 0;
    while (hirq !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, hirq}, 32'h1);
  endtask : wait_irq
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    {rst_n, fv, mac, am, mh, ph, fl, rv, rs, flen} = '0;
    ncb = NCB_I_FRAME;
    fbuf = 16'h0140;
    fnb = 16'h1234;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({chain, 14'h0, txe, hirq}, 32'h0);
    cmd(RXOPT_NORMAL, CMD_RX_FILTER, RC_CLOSED);
    host_u.xfer(1'b1, OFS_OPEN, 32'h0001_0000, q);
    for (i = 0; i < 10; i++) begin
      cmd(rows[i][19:4], CMD_RX_FILTER, RC_OK);
      frame(rows[i][3], rows[i][2], 1'b0, rows[i][1], rows[i][0], 1'b0);
    end
    cmd(16'h0001, CMD_RX_FILTER, RC_BAD_OPT);
    cmd(16'h0000, 8'h33, RC_BAD_CMD);
    cmd(16'h0000, CMD_SLEEP, RC_BAD_OPT);
    chk({16'h0, chain}, 32'h1236);
    wait_irq();
    host_u.note_rd(NOTE_BASE, q);
    chk({16'h0, q[15:0]}, 32'h81);
    host_u.xfer(1'b0, OFS_WINDOW, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h81);
    host_u.note_rd(NOTE_BASE + 20'h6, q);
    chk({16'h0, q[15:0]}, 32'h0140);
    rs <= 16'h00a5;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    host_u.xfer(1'b1, OFS_NOTE_ACK, 32'h0, q);
    wait_irq();
    host_u.note_rd(NOTE_BASE, q);
    chk({16'h0, q[15:0]}, 32'h84);
    host_u.note_rd(NOTE_BASE + 20'h6, q);
    chk({16'h0, q[15:0]}, 32'h00a5);
    host_u.xfer(1'b1, OFS_NOTE_ACK, 32'h0, q);
    fl <= 1'b1;
    frame(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    chk({16'h0, chain}, 32'h0);
    host_u.xfer(1'b1, OFS_HOST_RESP, {24'h0, RC_NO_BUF}, q);
    chk({31'h0, lbusy}, 32'h1);
    host_u.xfer(1'b1, OFS_BUSY, 32'h1, q);
    chk({31'h0, lbusy}, 32'h0);
    host_u.xfer(1'b0, 8'h40, 32'h0, q);
    chk({31'h0, pslverr}, 32'h1);
    wait_irq();
    host_u.xfer(1'b1, OFS_NOTE_ACK, 32'h0, q);
    // Reopen with MAC forwarding enabled by open options
    host_u.xfer(1'b1, OFS_OPEN, 32'h0001_0018, q);
    frame(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    wait_irq();
    host_u.xfer(1'b1, OFS_NOTE_ACK, 32'h0, q);
    repeat (3) @(posedge clk);
    cmd(WAKE_PATTERN, CMD_SLEEP, RC_OK);
    host_u.xfer(1'b1, OFS_CMD, {16'h0, CMD_RX_FILTER}, q);
    host_u.xfer(1'b0, OFS_STATUS, 32'h0, q);
    chk({23'h0, q[ST_ASLEEP], q[7:0]}, 32'h100);
    chk({30'h0, txe, ins}, 32'h1);
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    frame(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    // Magic hit must not wake while only pattern is selected
    frame(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    #1 chk({30'h0, wirq, hirq}, 32'h0);
    @(posedge clk);
    ph <= 1'b1;
    frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    #1 chk({31'h0, wirq}, 32'h1);
    ph <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, txe}, 32'h1);
    cmd(WAKE_MAGIC, CMD_SLEEP, RC_OK);
    frame(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    #1 chk({31'h0, wirq}, 32'h1);
    end_of_test();
  end
endmodule : rx_filter_sleep_arb_notify_tb
